/* File: logic/mct_device.sv */
// memory cycle timing and control sequencer, device end
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module mct_device (
  input  wire logic       clk,
  input  wire logic       rst,
  mct_link_if.device      link,
  input  wire logic       powerOnClear_n,
  output logic            memoryInitiate_n,
  output logic [7:0]      regStrobeLane,
  output logic            writeEnable,
  output logic            writeOuterEnable,
  output logic            writeInnerEnable,
  output logic            transferCycle_n,
  output logic            xferEnable,
  output logic            outEnable,
  output logic            dataStrobe,
  output logic            outerWordHeld,
  output logic            innerWordHeld,
  output logic            bufferReadSelectHeld,
  output logic            ioReadSelectHeld,
  output logic            bufferOutSelect,
  output logic            ioOutSelect
);
  mct_pkg::mct_cycle_s cyc;
  logic                clear;
  logic                initiate;
  logic                busy;
  logic                protPulse;
  logic                winitPulse;
  logic                winitFirst;
  logic                strobeBase;
  logic                strobeBase_n;
  logic                rselPulse;
  logic                xeSet;
  logic                xeClr;
  logic                xsSet;
  logic                xsClr;
  logic                ctlRst;
  logic                oeSet;
  logic                oeClr;
  logic                osSet;
  logic                osClr;
  logic                transferFf;
  logic                protectErrorFf;
  logic                violation;
  logic                protGate;
  logic                readCycle;
  logic                bufferReadSelect;
  logic                ioReadSelect;
  logic [1:0]          reqSel;
  logic                overrideWords;

  assign clear = rst || !powerOnClear_n;

  // later requests while a cycle runs are ignored
  assign initiate = !busy && ((link.cycleRequest && link.memoryChipSelect)
                    || !link.transferRequest_n);

  assign reqSel = {link.dataSelectB, link.dataSelectA};
  // cu and io writes always move full words
  assign overrideWords = link.readWriteCtl && link.transferRequest_n
                         && (reqSel != `MCT_SEL_PE);

  mct_timing_chain chain (
    .clk        (clk),
    .clear      (clear),
    .initiate   (initiate),
    .busy       (busy),
    .protPulse  (protPulse),
    .winitPulse (winitPulse),
    .winitFirst (winitFirst),
    .strobeBase (strobeBase),
    .rselPulse  (rselPulse),
    .xeSet      (xeSet),
    .xeClr      (xeClr),
    .xsSet      (xsSet),
    .xsClr      (xsClr),
    .ctlRst     (ctlRst),
    .oeSet      (oeSet),
    .oeClr      (oeClr),
    .osSet      (osSet),
    .osClr      (osClr)
  );

  // command levels are caught once per cycle at initiate
  always_ff @(posedge clk) begin
    if (clear) begin
      cyc <= '0;
    end else if (initiate) begin
      cyc.isTransfer <= !link.transferRequest_n;
      cyc.isWrite    <= link.readWriteCtl && link.transferRequest_n;
      cyc.protEn     <= link.protectEnable;
      cyc.protBits   <= link.protectBits;
      cyc.dataSel    <= reqSel;
    end
  end

  assign violation = cyc.protEn && (cyc.protBits == `MCT_PROT_BLOCK);
  assign protGate  = protPulse && !transferFf;
  assign readCycle = !cyc.isWrite && !cyc.isTransfer;

  always_ff @(posedge clk) begin
    if (clear) begin
      transferFf <= 1'b0;
    end else if (initiate) begin
      transferFf <= !link.transferRequest_n;
    end else if (ctlRst) begin
      transferFf <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      writeEnable <= 1'b0;
    end else if (ctlRst) begin
      writeEnable <= 1'b0;
    end else if (protGate && cyc.isWrite && !violation) begin
      writeEnable <= 1'b1;
    end
  end

  // set wins over a clear arriving in the same clock
  always_ff @(posedge clk) begin
    if (clear) begin
      protectErrorFf <= 1'b0;
    end else if (protGate && cyc.isWrite && violation) begin
      protectErrorFf <= 1'b1;
    end else if (!link.protectErrorClear_n) begin
      protectErrorFf <= 1'b0;
    end
  end

  // read cycles get a single clock, writes the whole pulse
  always_ff @(posedge clk) begin
    if (clear) begin
      memoryInitiate_n <= 1'b1;
    end else begin
      memoryInitiate_n <= !(winitPulse && !transferFf
                            && (cyc.isWrite || winitFirst));
    end
  end

  assign strobeBase_n = !strobeBase;
  // lanes 4-7 come from the complement path to split fan-out
  always_ff @(posedge clk) begin
    if (clear) begin
      regStrobeLane <= 8'h00;
    end else begin
      regStrobeLane <= {{4{!strobeBase_n}}, {4{strobeBase}}};
    end
  end

  assign bufferReadSelect = readCycle && (cyc.dataSel == `MCT_SEL_CU);
  assign ioReadSelect     = readCycle && (cyc.dataSel == `MCT_SEL_IO);

  // held through the output-enable period, dropped as it ends
  always_ff @(posedge clk) begin
    if (clear) begin
      bufferReadSelectHeld <= 1'b0;
      ioReadSelectHeld     <= 1'b0;
    end else if (rselPulse) begin
      bufferReadSelectHeld <= bufferReadSelect;
      ioReadSelectHeld     <= ioReadSelect;
    end else if (oeClr) begin
      bufferReadSelectHeld <= 1'b0;
      ioReadSelectHeld     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      xferEnable <= 1'b0;
    end else if (xeClr) begin
      xferEnable <= 1'b0;
    end else if (xeSet) begin
      xferEnable <= 1'b1;
    end
  end

  // the output window set overlaps the transfer reset by a clock
  always_ff @(posedge clk) begin
    if (clear) begin
      dataStrobe <= 1'b0;
    end else if (xsSet || osSet) begin
      dataStrobe <= 1'b1;
    end else if (xsClr || osClr) begin
      dataStrobe <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      outEnable <= 1'b0;
    end else if (oeClr) begin
      outEnable <= 1'b0;
    end else if (oeSet) begin
      outEnable <= 1'b1;
    end
  end

  // word latches restart at each initiate, then only set
  always_ff @(posedge clk) begin
    if (clear) begin
      outerWordHeld <= 1'b0;
      innerWordHeld <= 1'b0;
    end else if (initiate) begin
      outerWordHeld <= link.outerWordEnable || overrideWords;
      innerWordHeld <= link.innerWordEnable || overrideWords;
    end else if (busy) begin
      if (link.outerWordEnable) begin
        outerWordHeld <= 1'b1;
      end
      if (link.innerWordEnable) begin
        innerWordHeld <= 1'b1;
      end
    end
  end

  assign writeOuterEnable = writeEnable && outerWordHeld;
  assign writeInnerEnable = writeEnable && innerWordHeld;
  assign transferCycle_n  = !transferFf;
  assign bufferOutSelect  = (xferEnable && cyc.isTransfer)
                            || (outEnable && readCycle);
  assign ioOutSelect      = outEnable && readCycle && ioReadSelectHeld;

  assign link.protectError = protectErrorFf;
  assign link.cycleBusy    = busy;
endmodule : mct_device
`default_nettype wire

/* File: logic/mct_host.sv */
// controller end: axi4-lite registers drive the command lines
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module mct_host (
  input  wire logic        clk,
  input  wire logic        rst,
  mct_link_if.host         link,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic [31:0] cmdReg;
  logic [11:0] awAddr;
  logic        awHeld;
  logic [31:0] wData;
  logic        wHeld;
  logic        doWrite;
  logic        memReq;
  logic        xferReq;
  logic        clrReq;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHeld && wHeld;

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // strobes ignored: every write takes the whole word
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MCT_RESP_OKAY;
      cmdReg       <= `MCT_CMD_RESET;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr == `MCT_REG_CMD || awAddr == `MCT_REG_GO)
                      ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;
      if (awAddr == `MCT_REG_CMD) begin
        cmdReg <= wData;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // one-clock command pulses; a start while busy is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      memReq  <= 1'b0;
      xferReq <= 1'b0;
      clrReq  <= 1'b0;
    end else begin
      memReq  <= doWrite && (awAddr == `MCT_REG_GO)
                 && wData[`MCT_GO_MEM] && !link.cycleBusy;
      xferReq <= doWrite && (awAddr == `MCT_REG_GO) && !wData[`MCT_GO_MEM]
                 && wData[`MCT_GO_XFER] && !link.cycleBusy;
      clrReq  <= doWrite && (awAddr == `MCT_REG_GO)
                 && wData[`MCT_GO_CLR];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MCT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `MCT_RESP_OKAY;
      unique case (s_axi_araddr)
        `MCT_REG_CMD:    s_axi_rdata <= cmdReg;
        `MCT_REG_STATUS: s_axi_rdata <= {30'h0, link.cycleBusy,
                                         link.protectError};
        `MCT_REG_GO:     s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `MCT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // levels stay valid from one request to the next
  assign link.cycleRequest        = memReq;
  assign link.transferRequest_n   = !xferReq;
  assign link.memoryChipSelect    = cmdReg[`MCT_CMD_MSEL];
  assign link.readWriteCtl        = cmdReg[`MCT_CMD_RW];
  assign link.protectEnable       = cmdReg[`MCT_CMD_PROT];
  assign link.dataSelectA         = cmdReg[`MCT_CMD_SELA];
  assign link.dataSelectB         = cmdReg[`MCT_CMD_SELB];
  assign link.protectBits         = cmdReg[`MCT_CMD_PBITS_LO +: 4];
  assign link.protectErrorClear_n = !clrReq;
  assign link.outerWordEnable     = (memReq || xferReq)
                                    && cmdReg[`MCT_CMD_OUTER];
  assign link.innerWordEnable     = (memReq || xferReq)
                                    && cmdReg[`MCT_CMD_INNER];
endmodule : mct_host
`default_nettype wire

/* File: logic/mct_link_if.sv */
// command and status lines between controller and sequencer
`timescale 1ns/1ps
`default_nettype none
interface mct_link_if;
  logic       cycleRequest;
  logic       memoryChipSelect;
  logic       transferRequest_n;
  logic       readWriteCtl;
  logic       protectEnable;
  logic       protectErrorClear_n;
  logic       dataSelectA;
  logic       dataSelectB;
  logic       outerWordEnable;
  logic       innerWordEnable;
  logic [3:0] protectBits;
  logic       protectError;
  logic       cycleBusy;

  modport device (
    input  cycleRequest, memoryChipSelect, transferRequest_n, readWriteCtl,
           protectEnable, protectErrorClear_n, dataSelectA, dataSelectB,
           outerWordEnable, innerWordEnable, protectBits,
    output protectError, cycleBusy
  );
  modport host (
    output cycleRequest, memoryChipSelect, transferRequest_n, readWriteCtl,
           protectEnable, protectErrorClear_n, dataSelectA, dataSelectB,
           outerWordEnable, innerWordEnable, protectBits,
    input  protectError, cycleBusy
  );
endinterface : mct_link_if
`default_nettype wire

/* File: logic/mct_map.svh */
// constants for the memory cycle timing and control block
`ifndef MCT_MAP_SVH
`define MCT_MAP_SVH

`define MCT_CLK_NS        8
`define MCT_NS2CYC(t)     (((t) + `MCT_CLK_NS / 2) / `MCT_CLK_NS)
`define MCT_CNT_W         6

`define MCT_PULSE_NS      50
`define MCT_STROBE_NS     8
`define MCT_PROT_NS       40
`define MCT_WINIT_NS      55
`define MCT_RSEL_NS       130
`define MCT_XE_SET_NS     165
`define MCT_XS_SET_NS     185
`define MCT_XS_CLR_NS     245
`define MCT_CTL_RST_NS    250
`define MCT_XE_CLR_NS     265
`define MCT_OE_SET_NS     270
`define MCT_OS_SET_NS     290
`define MCT_OS_CLR_NS     350
`define MCT_OE_CLR_NS     370

`define MCT_PULSE_CYC     `MCT_NS2CYC(`MCT_PULSE_NS)
`define MCT_STROBE_CYC    `MCT_NS2CYC(`MCT_STROBE_NS)
`define MCT_PROT_CYC      `MCT_NS2CYC(`MCT_PROT_NS)
`define MCT_WINIT_CYC     `MCT_NS2CYC(`MCT_WINIT_NS)
`define MCT_RSEL_CYC      `MCT_NS2CYC(`MCT_RSEL_NS)
`define MCT_XE_SET_CYC    `MCT_NS2CYC(`MCT_XE_SET_NS)
`define MCT_XS_SET_CYC    `MCT_NS2CYC(`MCT_XS_SET_NS)
`define MCT_XS_CLR_CYC    `MCT_NS2CYC(`MCT_XS_CLR_NS)
`define MCT_CTL_RST_CYC   `MCT_NS2CYC(`MCT_CTL_RST_NS)
`define MCT_XE_CLR_CYC    `MCT_NS2CYC(`MCT_XE_CLR_NS)
`define MCT_OE_SET_CYC    `MCT_NS2CYC(`MCT_OE_SET_NS)
`define MCT_OS_SET_CYC    `MCT_NS2CYC(`MCT_OS_SET_NS)
`define MCT_OS_CLR_CYC    `MCT_NS2CYC(`MCT_OS_CLR_NS)
`define MCT_OE_CLR_CYC    `MCT_NS2CYC(`MCT_OE_CLR_NS)
`define MCT_LAST_CYC      (`MCT_OE_CLR_CYC + `MCT_PULSE_CYC - 1)

`define MCT_SEL_PE        2'h0
`define MCT_SEL_CU        2'h1
`define MCT_SEL_IO        2'h2
`define MCT_PROT_BLOCK    4'h0

`define MCT_REG_CMD       12'h000
`define MCT_REG_GO        12'h004
`define MCT_REG_STATUS    12'h008
`define MCT_CMD_RESET     32'h0000_0000
`define MCT_CMD_RW        0
`define MCT_CMD_MSEL      1
`define MCT_CMD_PROT      2
`define MCT_CMD_SELA      3
`define MCT_CMD_SELB      4
`define MCT_CMD_OUTER     5
`define MCT_CMD_INNER     6
`define MCT_CMD_PBITS_LO  8
`define MCT_GO_MEM        0
`define MCT_GO_XFER       1
`define MCT_GO_CLR        2
`define MCT_ST_PERR       0
`define MCT_ST_BUSY       1
`define MCT_RESP_OKAY     2'h0
`define MCT_RESP_SLVERR   2'h2

`endif

/* File: logic/mct_pkg.sv */
// types shared by the device end of the memory cycle sequencer and its timing chain
`default_nettype none
package mct_pkg;
  typedef enum logic {MCT_IDLE, MCT_RUN} mct_state_e;

  typedef struct packed {
    logic       isWrite;
    logic       isTransfer;
    logic       protEn;
    logic [3:0] protBits;
    logic [1:0] dataSel;
  } mct_cycle_s;
endpackage : mct_pkg
`default_nettype wire

/* File: logic/mct_timing_chain.sv */
// cycle counter and timed pulse taps of the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module mct_timing_chain (
  input  wire logic clk,
  input  wire logic clear,
  input  wire logic initiate,
  output logic      busy,
  output logic      protPulse,
  output logic      winitPulse,
  output logic      winitFirst,
  output logic      strobeBase,
  output logic      rselPulse,
  output logic      xeSet,
  output logic      xeClr,
  output logic      xsSet,
  output logic      xsClr,
  output logic      ctlRst,
  output logic      oeSet,
  output logic      oeClr,
  output logic      osSet,
  output logic      osClr
);
  mct_pkg::mct_state_e          state;
  logic [`MCT_CNT_W-1:0]        count;

  function automatic logic inWin(input logic [`MCT_CNT_W-1:0] c,
                                 input int unsigned start,
                                 input int unsigned width);
    int unsigned cw;
    cw = 32'(c);
    inWin = (cw >= start) && (cw < start + width);
  endfunction : inWin

  // count k marks k clocks after the initiate pulse
  always_ff @(posedge clk) begin
    if (clear) begin
      state <= mct_pkg::MCT_IDLE;
      count <= '0;
    end else begin
      unique case (state)
        mct_pkg::MCT_IDLE: begin
          if (initiate) begin
            state <= mct_pkg::MCT_RUN;
            count <= `MCT_CNT_W'(1);
          end
        end
        mct_pkg::MCT_RUN: begin
          if (32'(count) == `MCT_LAST_CYC) begin
            state <= mct_pkg::MCT_IDLE;
            count <= '0;
          end else begin
            count <= count + `MCT_CNT_W'(1);
          end
        end
      endcase
    end
  end

  // taps rounded to the nearest clock edge
  always_comb begin
    busy       = (state == mct_pkg::MCT_RUN);
    protPulse  = busy && inWin(count, `MCT_PROT_CYC, `MCT_PULSE_CYC);
    winitPulse = busy && inWin(count, `MCT_WINIT_CYC, `MCT_PULSE_CYC);
    winitFirst = busy && (32'(count) == `MCT_WINIT_CYC);
    strobeBase = busy && inWin(count, `MCT_WINIT_CYC, `MCT_STROBE_CYC);
    rselPulse  = busy && inWin(count, `MCT_RSEL_CYC, `MCT_PULSE_CYC);
    xeSet      = busy && inWin(count, `MCT_XE_SET_CYC, `MCT_PULSE_CYC);
    xeClr      = busy && inWin(count, `MCT_XE_CLR_CYC, `MCT_PULSE_CYC);
    xsSet      = busy && inWin(count, `MCT_XS_SET_CYC, `MCT_PULSE_CYC);
    xsClr      = busy && inWin(count, `MCT_XS_CLR_CYC, `MCT_PULSE_CYC);
    ctlRst     = busy && inWin(count, `MCT_CTL_RST_CYC, `MCT_PULSE_CYC);
    oeSet      = busy && inWin(count, `MCT_OE_SET_CYC, `MCT_PULSE_CYC);
    oeClr      = busy && inWin(count, `MCT_OE_CLR_CYC, `MCT_PULSE_CYC);
    osSet      = busy && inWin(count, `MCT_OS_SET_CYC, `MCT_PULSE_CYC);
    osClr      = busy && inWin(count, `MCT_OS_CLR_CYC, `MCT_PULSE_CYC);
  end
endmodule : mct_timing_chain
`default_nettype wire

/* File: tb/mct_link_asserts.sv */
// concurrent checks on the link between controller and sequencer
`timescale 1ns/1ps
`default_nettype none
module mct_link_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       powerOnClear_n,
  input wire logic       cycleRequest,
  input wire logic       memoryChipSelect,
  input wire logic       transferRequest_n,
  input wire logic       readWriteCtl,
  input wire logic       protectEnable,
  input wire logic       protectErrorClear_n,
  input wire logic [3:0] protectBits,
  input wire logic       protectError,
  input wire logic       cycleBusy
);
  default clocking cb @(posedge clk);
  endclocking
  // power clear aborts a running cycle, so it disables checks too
  default disable iff (rst || !powerOnClear_n);
  logic take;
  logic prot;
  assign take = !cycleBusy && (cycleRequest && memoryChipSelect
                || !transferRequest_n);
  assign prot = protectEnable && protectBits == 4'h0;
  a_take_busy: assert property (take |=> cycleBusy)
    else $error("cycle not started");
  a_idle_hold: assert property (!cycleBusy && !take |=> !cycleBusy)
    else $error("cycle started without request");
  a_busy_span: assert property ($rose(cycleBusy) |->
    ##50 cycleBusy ##1 !cycleBusy)
    else $error("busy length wrong");
  a_prot_set: assert property (take && transferRequest_n && readWriteCtl
    && prot |-> ##6 protectError)
    else $error("protect error not set");
  a_prot_free: assert property (take && readWriteCtl && !prot
    && !protectError |-> ##6 !protectError)
    else $error("false protect error on write");
  a_prot_read: assert property (take && !readWriteCtl && !protectError
    |-> ##6 !protectError)
    else $error("protect error on read");
  a_prot_xfer: assert property (take && !transferRequest_n
    && !protectError |-> ##6 !protectError)
    else $error("protect error on transfer");
  a_err_clear: assert property (!protectErrorClear_n && !cycleBusy
    |=> !protectError)
    else $error("protect error not cleared");
  a_err_keep: assert property (protectError && protectErrorClear_n
    |=> protectError)
    else $error("protect error lost");
endmodule : mct_link_asserts
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench: controller and sequencer joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module testbench;
  logic clk = 1'b0, rst = 1'b1, poc_n = 1'b1;
  logic [11:0] awA = 12'h0, arA = 12'h0;
  logic [31:0] wD = 32'h0, rD;
  logic awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
  logic awR, wR, bV, arR, rV;
  logic [1:0] bR, rR;
  logic miN, woe, wie, tcN, we, xe, oe, ds, owh, iwh, brh, irh, bos, ios;
  logic [7:0] lane;
  int miscompares = 0, nTests = 0, cycles = 0;
  always #4 clk = ~clk;
  mct_link_if link ();
  mct_host i_mct_host (.clk(clk), .rst(rst), .link(link),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
    .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_bresp(bR), .s_axi_bvalid(bV),
    .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rR),
    .s_axi_rvalid(rV), .s_axi_rready(rRdy));
  mct_device i_mct_device (.clk(clk), .rst(rst), .link(link),
    .powerOnClear_n(poc_n), .memoryInitiate_n(miN), .regStrobeLane(lane),
    .writeEnable(we), .writeOuterEnable(woe), .writeInnerEnable(wie),
    .transferCycle_n(tcN), .xferEnable(xe), .outEnable(oe),
    .dataStrobe(ds), .outerWordHeld(owh), .innerWordHeld(iwh),
    .bufferReadSelectHeld(brh), .ioReadSelectHeld(irh),
    .bufferOutSelect(bos), .ioOutSelect(ios));
  mct_link_asserts i_mct_link_asserts (.clk(clk), .rst(rst),
    .powerOnClear_n(poc_n), .cycleRequest(link.cycleRequest),
    .memoryChipSelect(link.memoryChipSelect),
    .transferRequest_n(link.transferRequest_n),
    .readWriteCtl(link.readWriteCtl), .protectEnable(link.protectEnable),
    .protectErrorClear_n(link.protectErrorClear_n),
    .protectBits(link.protectBits), .protectError(link.protectError),
    .cycleBusy(link.cycleBusy));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic endOfTest();
    if (miscompares == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : endOfTest
  always @(posedge clk) begin
    cycles++;
    // whole run needs under a thousand cycles
    if (cycles == 3000) begin
      miscompares++;
      endOfTest();
    end
  end
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bRdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awR) awV <= 1'b0;
      if (wR) wV <= 1'b0;
    end while (!bV);
    bRdy <= 1'b0;
  endtask : axiWr
  task automatic axiRd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    arA <= a;
    arV <= 1'b1;
    rRdy <= 1'b1;
    do begin
      @(posedge clk);
      if (arR) arV <= 1'b0;
    end while (!rV);
    rRdy <= 1'b0;
    check(rD, exp);
    check(32'(rR), 32'(`MCT_RESP_OKAY));
  endtask : axiRd
  // one full cycle traced against the timing points, every clock
  task automatic cyc(input logic [31:0] c, input logic x);
    logic w, rd, xw, ow, ww, ov;
    w = c[0] & !x;
    rd = !c[0] & !x;
    // cu and io writes force both word latches
    ov = w && c[4:3] != 2'h0;
    axiWr(`MCT_REG_CMD, c);
    axiWr(`MCT_REG_GO, x ? 32'h2 : 32'h1);
    // the edge that returns is the one that takes the request
    while (link.cycleRequest !== 1'b1 && link.transferRequest_n !== 1'b0)
      @(posedge clk);
    for (int k = 1; k < 53; k++) begin
      #1;
      xw = k > 21 && k < 34;
      ow = k > 34 && k < 47;
      ww = w && k > 5 && k < 32;
      check(32'({link.cycleBusy, miN, lane, we, xe, oe, ds, bos, ios}),
        32'({k < 52, !(w && k > 7 && k < 14 || rd && k == 8),
        k == 8 ? 8'hFF : 8'h00, ww, xw, ow,
        k > 23 && k < 32 || k > 36 && k < 45, x ? xw : rd && ow,
        rd && c[4:3] == 2'h2 && ow}));
      if (k == 10)
        check(32'({tcN, owh, iwh, woe, wie}), 32'({!x, c[5] | ov, c[6] | ov,
          ww & (c[5] | ov), ww & (c[6] | ov)}));
      if (rd && (k == 20 || k == 48))
        check(32'({brh, irh}), k == 20 ? 32'({c[4:3] == 2'h1,
          c[4:3] == 2'h2}) : 32'h0);
      @(posedge clk);
    end
  endtask : cyc
  task automatic tProt();
    logic seenWe;
    seenWe = 1'b0;
    axiWr(`MCT_REG_CMD, 32'h7);
    axiWr(`MCT_REG_GO, 32'h1);
    repeat (60) begin
      @(posedge clk);
      seenWe |= we;
    end
    check(32'(seenWe), 32'h0);
    axiRd(`MCT_REG_STATUS, 32'h1);
    axiWr(`MCT_REG_GO, 32'h4);
    axiRd(`MCT_REG_STATUS, 32'h0);
  endtask : tProt
  task automatic tRefuse();
    axiWr(`MCT_REG_CMD, 32'h21);
    axiWr(`MCT_REG_GO, 32'h1);
    repeat (8) @(posedge clk);
    check(32'(link.cycleBusy), 32'h0);
    axiWr(`MCT_REG_CMD, 32'h23);
    axiWr(`MCT_REG_GO, 32'h1);
    axiWr(`MCT_REG_GO, 32'h1);
    repeat (52) @(posedge clk);
    #1;
    check(32'(link.cycleBusy), 32'h0);
    axiRd(`MCT_REG_CMD, 32'h23);
    axiWr(12'hFFC, 32'h1);
    check(32'(bR), 32'(`MCT_RESP_SLVERR));
  endtask : tRefuse
  task automatic tPowerClear();
    axiWr(`MCT_REG_GO, 32'h1);
    repeat (12) @(posedge clk);
    poc_n <= 1'b0;
    @(posedge clk);
    poc_n <= 1'b1;
    #1;
    check(32'({link.cycleBusy, we, miN, tcN}), 32'h3);
  endtask : tPowerClear
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(32'({miN, tcN, lane, we, xe, oe, ds, bos, ios, link.protectError,
      link.cycleBusy}), 32'h0003_0000);
    cyc(32'h23, 1'b0);
    cyc(32'h10F, 1'b0);
    cyc(32'h12, 1'b0);
    cyc(32'h0A, 1'b0);
    cyc(32'h64, 1'b1);
    tProt();
    tRefuse();
    tPowerClear();
    endOfTest();
  end
endmodule : testbench
`default_nettype wire
